//--- common/tlp_check_pkg.sv
// Purpose: Shared constants, types and header helpers for the received packet checker pair.
// Assumes: Packets move one 32-bit doubleword per beat, header first, on one clock.
// Notes:   The rules that the pair keeps follow, one per line.
// Functional notes
// (RQ1) Check only packets received from the link.
// (RQ2) User logic checks every packet it transmits.
// (RQ3) Payload above max payload setting is malformed.
// (RQ4) Data amount must match the length field.
// (RQ5) Digest presence must match the TD bit.
// (RQ6) User optionally checks first and last byte enables.
// (RQ7) User optionally flags non-contiguous byte enables.
// (RQ8) Request tag width must suit tag configuration.
// (RQ9) User checks tag width both directions.
// (RQ10) Memory writes crossing 4 KB are malformed.
// (RQ11) User optionally checks memory reads crossing 4 KB.
// (RQ12) I/O requests need fixed TC, Attr, AT, length, BE.
// (RQ13) Config requests need fixed TC, Attr, AT, length, BE.
// (RQ14) Config requests must target an existing function.
// (RQ15) Interrupt messages only from upstream ports.
// (RQ16) Interrupt messages must use traffic class zero.
// (RQ17) Malformed packets are dropped and an error raised; the user end only flags its faults and still forwards the packet.
package tlp_check_pkg;
  localparam int DW_W      = 32;
  localparam int CNT_W     = 12;
  localparam int BUF_AW    = 11;
  localparam int BUF_DEPTH = 2048;
  localparam int ADDR_W    = 10;
  localparam int HDR_WORDS = 4;
  localparam int CAP_W     = 3;
  localparam int CH_COUNT  = 2;
  localparam int CH_RX     = 0;
  localparam int CH_TX     = 1;
  // Header word indices.
  localparam int HDR_W0 = 0;
  localparam int HDR_W1 = 1;
  localparam int HDR_W2 = 2;
  localparam int HDR_W3 = 3;
  // Field positions in header words.
  localparam int FMT_DATA_BIT = 30;
  localparam int FMT_4DW_BIT  = 29;
  localparam int TYPE_HI      = 28;
  localparam int TYPE_LO      = 24;
  localparam int TC_HI        = 22;
  localparam int TC_LO        = 20;
  localparam int TD_BIT       = 15;
  localparam int ATTR_HI      = 13;
  localparam int ATTR_LO      = 12;
  localparam int AT_HI        = 11;
  localparam int AT_LO        = 10;
  localparam int LEN_HI       = 9;
  localparam int LEN_LO       = 0;
  localparam int TAG_EXT_HI   = 15;
  localparam int TAG_EXT_LO   = 13;
  localparam int LBE_HI       = 7;
  localparam int LBE_LO       = 4;
  localparam int FBE_HI       = 3;
  localparam int FBE_LO       = 0;
  localparam int MSGC_HI      = 7;
  localparam int MSGC_GRP_LO  = 3;
  localparam int FUNC_HI      = 18;
  localparam int FUNC_LO      = 16;
  localparam int ADDR_HI      = 11;
  localparam int ADDR_LO      = 2;
  localparam int QW_IDX       = 0;
  // Field values.
  localparam logic [4:0] TYPE_MEM     = 5'h00;
  localparam logic [4:0] TYPE_IO      = 5'h02;
  localparam logic [3:0] TYPE_CFG_HI4 = 4'h2;
  localparam logic [1:0] TYPE_MSG_HI2 = 2'h2;
  localparam logic [4:0] MSG_INTX_GRP = 5'h04;
  localparam logic [9:0] IO_CFG_LEN   = 10'h001;
  localparam logic [3:0] BE_NONE      = 4'h0;
  localparam logic [3:0] BE_ALL       = 4'hF;
  localparam logic [3:0] BE_ONE       = 4'h1;
  localparam logic [2:0] NUM_FUNCS    = 3'h1;
  localparam logic [CAP_W-1:0] CAP_ZERO = 3'h0;
  localparam logic [CAP_W-1:0] CAP_ONE  = 3'h1;
  localparam logic [CAP_W-1:0] CAP_MAX  = 3'h4;
  // Doubleword counts.
  localparam logic [CNT_W-1:0] NO_DW       = 12'h000;
  localparam logic [CNT_W-1:0] ONE_DW      = 12'h001;
  localparam logic [CNT_W-1:0] TWO_DW      = 12'h002;
  localparam logic [CNT_W-1:0] HDR3_DW     = 12'h003;
  localparam logic [CNT_W-1:0] HDR4_DW     = 12'h004;
  localparam logic [CNT_W-1:0] PAGE_DW     = 12'h400;
  localparam logic [CNT_W-1:0] MPS_BASE_DW = 12'h020;
  localparam logic [CNT_W-1:0] BUF_LIMIT   = 12'h800;
  localparam logic [CNT_W-1:0] CNT_MAX     = 12'hFFF;

  typedef enum logic [3:0] {
    ERR_NONE        = 4'h0,
    ERR_PAYLOAD     = 4'h1,
    ERR_LENGTH      = 4'h2,
    ERR_DIGEST      = 4'h3,
    ERR_TAG         = 4'h4,
    ERR_BOUNDARY    = 4'h5,
    ERR_IO          = 4'h6,
    ERR_CFG         = 4'h7,
    ERR_FUNC        = 4'h8,
    ERR_INTX_PORT   = 4'h9,
    ERR_INTX_TC     = 4'hA,
    ERR_BE          = 4'hB,
    ERR_BE_GAP      = 4'hC,
    ERR_RD_BOUNDARY = 4'hD
  } err_code_type;

  typedef enum logic [1:0] {
    ST_COLLECT = 2'b00,
    ST_JUDGE   = 2'b01,
    ST_SEND    = 2'b10
  } collect_state_type;

  // A zero length field means a full page of doublewords.
  function automatic logic [CNT_W-1:0] len_dw(input logic [DW_W-1:0] dw0);
    logic [CNT_W-1:0] n;
    n = {2'b00, dw0[LEN_HI:LEN_LO]};
    return (n == NO_DW) ? PAGE_DW : n;
  endfunction

  // True when an access leaves the 4 KB page it starts in.
  function automatic logic page_cross(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] n);
    logic [CNT_W-1:0] endDw;
    endDw = {2'b00, a} + n;
    return endDw > PAGE_DW;
  endfunction
endpackage

//--- common/tlp_link_if.sv
// Purpose: Joins the checking end and the user logic end.
// Assumes: One shared clock; the user end never stalls the received stream.
// Notes:   Received packets flow to the user, transmit packets flow back.
`timescale 1ns/10ps
interface tlp_link_if;
  logic [31:0] rxData;
  logic        rxValid;
  logic        rxSop;
  logic        rxEop;
  logic [31:0] txData;
  logic        txValid;
  logic        txSop;
  logic        txEop;

  modport dev (output rxData, output rxValid, output rxSop, output rxEop,
               input txData, input txValid, input txSop, input txEop);
  modport usr (input rxData, input rxValid, input rxSop, input rxEop,
               output txData, output txValid, output txSop, output txEop);
endinterface

//--- rtl/rx_malformed_checker.sv
// Purpose: Stores each packet from the link, checks it, then forwards or drops it.
// Assumes: Link side holds a beat while linkRxReady is low; user end never stalls.
// Notes:   Store and forward costs one packet of latency but lets bad packets vanish whole.
`timescale 1ns/10ps
module rx_malformed_checker (
  // Clock and reset.
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // User end.
  tlp_link_if.dev                           user,
  // Receive stream from the link.
  input  wire logic [tlp_check_pkg::DW_W-1:0] linkRxData,
  input  wire logic                         linkRxValid,
  input  wire logic                         linkRxSop,
  input  wire logic                         linkRxEop,
  output logic                              linkRxReady,
  // Transmit stream to the link.
  output logic [tlp_check_pkg::DW_W-1:0]    linkTxData,
  output logic                              linkTxValid,
  output logic                              linkTxSop,
  output logic                              linkTxEop,
  // Configuration.
  input  wire logic [2:0]                   maxPayloadCode,
  input  wire logic                         extTagEnable,
  input  wire logic                         downstreamPort,
  // Error report.
  output logic                              malformedPulse,
  output tlp_check_pkg::err_code_type       malformedCode
);
  import tlp_check_pkg::*;

  logic [DW_W-1:0]   pktBuf [BUF_DEPTH];
  collect_state_type state_reg;
  collect_state_type state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [CNT_W-1:0]  rdIdx_reg;
  logic [CNT_W-1:0]  rdIdx_next;
  logic              inPkt_reg;
  logic              inPkt_next;
  logic              overflow_reg;
  logic              overflow_next;
  logic              rxReady_reg;
  logic [DW_W-1:0]   upData_reg;
  logic              upValid_reg;
  logic              upSop_reg;
  logic              upEop_reg;
  logic [DW_W-1:0]   txData_reg;
  logic              txValid_reg;
  logic              txSop_reg;
  logic              txEop_reg;
  logic              malPulse_reg;
  err_code_type      malCode_reg;

  // Beat acceptance; stray beats outside a packet are discarded.
  wire              beatTaken = linkRxValid & rxReady_reg & (linkRxSop | inPkt_reg);
  wire [CNT_W-1:0]  wrIdx     = linkRxSop ? NO_DW : cnt_reg;
  wire              wrInRange = wrIdx < BUF_LIMIT;
  wire [CNT_W-1:0]  wrIdxInc  = (wrIdx == CNT_MAX) ? CNT_MAX : wrIdx + ONE_DW;
  wire              lastBeat  = rdIdx_reg == (cnt_reg - ONE_DW);

  // Header fields of the stored packet.
  wire [DW_W-1:0]   h0       = pktBuf[HDR_W0];
  wire [DW_W-1:0]   h1       = pktBuf[HDR_W1];
  wire [DW_W-1:0]   h2       = pktBuf[HDR_W2];
  wire [DW_W-1:0]   h3       = pktBuf[HDR_W3];
  wire              hasData  = h0[FMT_DATA_BIT];
  wire              is4Dw    = h0[FMT_4DW_BIT];
  wire [4:0]        pktType  = h0[TYPE_HI:TYPE_LO];
  wire [2:0]        tc       = h0[TC_HI:TC_LO];
  wire              td       = h0[TD_BIT];
  wire [1:0]        attr     = h0[ATTR_HI:ATTR_LO];
  wire [1:0]        at       = h0[AT_HI:AT_LO];
  wire [9:0]        lenField = h0[LEN_HI:LEN_LO];
  wire [3:0]        lastBe   = h1[LBE_HI:LBE_LO];
  wire [2:0]        tagExt   = h1[TAG_EXT_HI:TAG_EXT_LO];
  wire [2:0]        funcNum  = h2[FUNC_HI:FUNC_LO];
  wire [ADDR_W-1:0] addrLow  = is4Dw ? h3[ADDR_HI:ADDR_LO] : h2[ADDR_HI:ADDR_LO];
  wire [CNT_W-1:0]  lenDw    = len_dw(h0);

  // Packet classes.
  wire isMem  = pktType == TYPE_MEM;
  wire isMWr  = isMem & hasData;
  wire isIo   = pktType == TYPE_IO;
  wire isCfg  = pktType[4:1] == TYPE_CFG_HI4;
  wire isMsg  = pktType[4:3] == TYPE_MSG_HI2;
  wire isIntx = isMsg & (h1[MSGC_HI:MSGC_GRP_LO] == MSG_INTX_GRP);

  // Expected beat counts with and without the digest word.
  wire [CNT_W-1:0] hdrDw     = is4Dw ? HDR4_DW : HDR3_DW;
  wire [CNT_W-1:0] payDw     = hasData ? lenDw : NO_DW;
  wire [CNT_W-1:0] bodyDw    = hdrDw + payDw;
  wire [CNT_W-1:0] digestDw  = bodyDw + ONE_DW;
  wire [CNT_W-1:0] payLimit  = MPS_BASE_DW << maxPayloadCode;

  // Individual checks, all on the received packet only.
  wire payloadBad  = overflow_reg | (payDw > payLimit);                                     // RQ3
  wire digestBad   = (td & (cnt_reg == bodyDw)) | (~td & (cnt_reg == digestDw));            // RQ5
  wire lengthBad   = cnt_reg != (td ? digestDw : bodyDw);                                   // RQ4
  wire tagBad      = (isMem | isIo | isCfg) & ~isMWr & ~extTagEnable & (tagExt != 3'h0);  // RQ8
  wire boundaryBad = isMWr & page_cross(addrLow, lenDw);                                    // RQ10
  wire fixedBad    = (tc != 3'h0) | (attr != 2'h0) | (at != 2'h0) | (lenField != IO_CFG_LEN) | (lastBe != BE_NONE);
  wire ioBad       = isIo & fixedBad;                                                       // RQ12
  wire cfgBad      = isCfg & fixedBad;                                                      // RQ13
  wire funcBad     = isCfg & (funcNum >= NUM_FUNCS);                                        // RQ14
  wire intxPortBad = isIntx & ~downstreamPort;                                              // RQ15
  wire intxTcBad   = isIntx & (tc != 3'h0);                                                 // RQ16

  // Only one code is reported; a size fault hides the rest because the header may be junk.
  wire err_code_type judgeCode =
    payloadBad  ? ERR_PAYLOAD :
    digestBad   ? ERR_DIGEST :
    lengthBad   ? ERR_LENGTH :
    tagBad      ? ERR_TAG :
    boundaryBad ? ERR_BOUNDARY :
    ioBad       ? ERR_IO :
    cfgBad      ? ERR_CFG :
    funcBad     ? ERR_FUNC :
    intxPortBad ? ERR_INTX_PORT :
    intxTcBad   ? ERR_INTX_TC : ERR_NONE;
  wire judgeBad = (state_reg == ST_JUDGE) & (judgeCode != ERR_NONE);

  // Packet store; beats past the buffer are counted but not kept.
  always_ff @(posedge clk) begin
    if (beatTaken & wrInRange) begin
      pktBuf[wrIdx[BUF_AW-1:0]] <= linkRxData;  // RQ1
    end
  end

  // Collect, judge, then replay the packet to the user end.
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    rdIdx_next    = rdIdx_reg;
    inPkt_next    = inPkt_reg;
    overflow_next = overflow_reg;
    case (state_reg)
      ST_COLLECT: begin
        if (beatTaken) begin
          cnt_next      = wrIdxInc;
          overflow_next = (overflow_reg & ~linkRxSop) | ~wrInRange;
          inPkt_next    = ~linkRxEop;
          if (linkRxEop) begin
            state_next = ST_JUDGE;
          end
        end
      end
      ST_JUDGE: begin
        rdIdx_next = NO_DW;
        state_next = judgeBad ? ST_COLLECT : ST_SEND;  // RQ17
      end
      ST_SEND: begin
        rdIdx_next = rdIdx_reg + ONE_DW;
        if (lastBeat) begin
          state_next = ST_COLLECT;
        end
      end
      default: begin
        state_next = ST_COLLECT;
      end
    endcase
  end

  // Control state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_COLLECT;
      cnt_reg      <= NO_DW;
      rdIdx_reg    <= NO_DW;
      inPkt_reg    <= 1'b0;
      overflow_reg <= 1'b0;
      rxReady_reg  <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      rdIdx_reg    <= rdIdx_next;
      inPkt_reg    <= inPkt_next;
      overflow_reg <= overflow_next;
      rxReady_reg  <= state_next == ST_COLLECT;  // Stalls the link while judging or replaying.
    end
  end

  // Replay to the user end and error report.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upData_reg   <= '0;
      upValid_reg  <= 1'b0;
      upSop_reg    <= 1'b0;
      upEop_reg    <= 1'b0;
      malPulse_reg <= 1'b0;
      malCode_reg  <= ERR_NONE;
    end else begin
      upData_reg   <= pktBuf[rdIdx_reg[BUF_AW-1:0]];
      upValid_reg  <= state_reg == ST_SEND;
      upSop_reg    <= (state_reg == ST_SEND) & (rdIdx_reg == NO_DW);
      upEop_reg    <= (state_reg == ST_SEND) & lastBeat;
      malPulse_reg <= judgeBad;  // RQ17
      if (judgeBad) begin
        malCode_reg <= judgeCode;  // Holds the last fault until the next one.
      end
    end
  end

  // Transmit path is passed through unchecked; the user end owns those checks.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txData_reg  <= '0;
      txValid_reg <= 1'b0;
      txSop_reg   <= 1'b0;
      txEop_reg   <= 1'b0;
    end else begin
      txData_reg  <= user.txData;  // RQ1
      txValid_reg <= user.txValid;
      txSop_reg   <= user.txSop;
      txEop_reg   <= user.txEop;
    end
  end

  // Outputs.
  assign linkRxReady    = rxReady_reg;
  assign user.rxData    = upData_reg;
  assign user.rxValid   = upValid_reg;
  assign user.rxSop     = upSop_reg;
  assign user.rxEop     = upEop_reg;
  assign linkTxData     = txData_reg;
  assign linkTxValid    = txValid_reg;
  assign linkTxSop      = txSop_reg;
  assign linkTxEop      = txEop_reg;
  assign malformedPulse = malPulse_reg;
  assign malformedCode  = malCode_reg;
endmodule

//--- rtl/user_tlp_checker.sv
// Purpose: User logic end: optional checks on received packets and checks on transmit packets.
// Assumes: The application always accepts received beats; transmit beats arrive in whole packets.
// Notes:   Streams are forwarded one cycle late; a verdict pulses two cycles after the packet end.
`timescale 1ns/10ps
module user_tlp_checker (
  // Clock and reset.
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // Checking end.
  tlp_link_if.usr                             link,
  // Received packets to the application.
  output logic [tlp_check_pkg::DW_W-1:0]      appRxData,
  output logic                                appRxValid,
  output logic                                appRxSop,
  output logic                                appRxEop,
  // Transmit packets from the application.
  input  wire logic [tlp_check_pkg::DW_W-1:0] appTxData,
  input  wire logic                           appTxValid,
  input  wire logic                           appTxSop,
  input  wire logic                           appTxEop,
  // Configuration and verdicts.
  input  wire logic                           extTagEnable,
  output logic                                rxCheckPulse,
  output tlp_check_pkg::err_code_type         rxCheckCode,
  output logic                                txCheckPulse,
  output tlp_check_pkg::err_code_type         txCheckCode
);
  import tlp_check_pkg::*;

  logic [DW_W-1:0] chData  [CH_COUNT];
  logic            chValid [CH_COUNT];
  logic            chSop   [CH_COUNT];
  logic            chEop   [CH_COUNT];
  logic            chPulse [CH_COUNT];
  err_code_type    chCode  [CH_COUNT];
  logic [DW_W-1:0] fwdData_reg [CH_COUNT];
  logic            fwdValid_reg [CH_COUNT];
  logic            fwdSop_reg [CH_COUNT];
  logic            fwdEop_reg [CH_COUNT];

  // Channel sources.
  assign chData[CH_RX]  = link.rxData;
  assign chValid[CH_RX] = link.rxValid;
  assign chSop[CH_RX]   = link.rxSop;
  assign chEop[CH_RX]   = link.rxEop;
  assign chData[CH_TX]  = appTxData;  // RQ2
  assign chValid[CH_TX] = appTxValid;
  assign chSop[CH_TX]   = appTxSop;
  assign chEop[CH_TX]   = appTxEop;

  // One checker per direction; transmit packets are checked here because nothing downstream does.
  for (genvar g = 0; g < CH_COUNT; g++) begin : gCh
    logic [DW_W-1:0]  hdr_reg [HDR_WORDS];
    logic [CAP_W-1:0] cap_reg;
    logic             done_reg;
    logic             pulse_reg;
    err_code_type     code_reg;

    wire              beat    = chValid[g];
    wire [CAP_W-1:0]  capIdx  = chSop[g] ? CAP_ZERO : cap_reg;
    wire [DW_W-1:0]   h0      = hdr_reg[HDR_W0];
    wire [DW_W-1:0]   h1      = hdr_reg[HDR_W1];
    wire [CNT_W-1:0]  lenDw   = len_dw(h0);
    wire              hasData = h0[FMT_DATA_BIT];
    wire [4:0]        pType   = h0[TYPE_HI:TYPE_LO];
    wire              isMem   = pType == TYPE_MEM;
    wire              isIo    = pType == TYPE_IO;
    wire              isBeReq = isMem | isIo | (pType[4:1] == TYPE_CFG_HI4);
    wire [3:0]        fbe     = h1[FBE_HI:FBE_LO];
    wire [3:0]        lbe     = h1[LBE_HI:LBE_LO];
    wire [ADDR_W-1:0] addrLow = h0[FMT_4DW_BIT] ? hdr_reg[HDR_W3][ADDR_HI:ADDR_LO]
                                                : hdr_reg[HDR_W2][ADDR_HI:ADDR_LO];
    wire              fbeRun  = (fbe | (fbe - BE_ONE)) == BE_ALL;
    wire              lbeRun  = (lbe & (lbe + BE_ONE)) == BE_NONE;
    wire              multi   = lenDw > ONE_DW;
    wire              beBad   = isBeReq & (multi ? ((fbe == BE_NONE) | (lbe == BE_NONE))
                                                 : (lbe != BE_NONE));                      // RQ6
    wire              gapBad  = isBeReq & ((lenDw > TWO_DW) | ((lenDw == TWO_DW) & addrLow[QW_IDX]))
                                & ~(fbeRun & lbeRun);                                       // RQ7
    wire              tagBad  = (isMem | isIo) & ~(isMem & hasData) & ~extTagEnable
                                & (h1[TAG_EXT_HI:TAG_EXT_LO] != 3'h0);                     // RQ9
    wire              rdBad   = isMem & ~hasData & page_cross(addrLow, lenDw);              // RQ11
    wire err_code_type code   = beBad  ? ERR_BE :
                                gapBad ? ERR_BE_GAP :
                                tagBad ? ERR_TAG :
                                rdBad  ? ERR_RD_BOUNDARY : ERR_NONE;

    // Header capture; the verdict waits a cycle so a header-only packet is complete.
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        for (int i = 0; i < HDR_WORDS; i++) begin
          hdr_reg[i] <= '0;
        end
        cap_reg   <= CAP_ZERO;
        done_reg  <= 1'b0;
        pulse_reg <= 1'b0;
        code_reg  <= ERR_NONE;
      end else begin
        if (beat & (capIdx < CAP_MAX)) begin
          hdr_reg[capIdx[1:0]] <= chData[g];
        end
        if (beat) begin
          cap_reg <= (capIdx == CAP_MAX) ? CAP_MAX : capIdx + CAP_ONE;
        end
        done_reg  <= beat & chEop[g];
        pulse_reg <= done_reg & (code != ERR_NONE);
        if (done_reg & (code != ERR_NONE)) begin
          code_reg <= code;
        end
      end
    end

    // Forwarding stage.
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        fwdData_reg[g]  <= '0;
        fwdValid_reg[g] <= 1'b0;
        fwdSop_reg[g]   <= 1'b0;
        fwdEop_reg[g]   <= 1'b0;
      end else begin
        fwdData_reg[g]  <= chData[g];
        fwdValid_reg[g] <= chValid[g];
        fwdSop_reg[g]   <= chSop[g];
        fwdEop_reg[g]   <= chEop[g];
      end
    end

    assign chPulse[g] = pulse_reg;
    assign chCode[g]  = code_reg;
  end

  // Outputs.
  assign appRxData    = fwdData_reg[CH_RX];
  assign appRxValid   = fwdValid_reg[CH_RX];
  assign appRxSop     = fwdSop_reg[CH_RX];
  assign appRxEop     = fwdEop_reg[CH_RX];
  assign link.txData  = fwdData_reg[CH_TX];
  assign link.txValid = fwdValid_reg[CH_TX];
  assign link.txSop   = fwdSop_reg[CH_TX];
  assign link.txEop   = fwdEop_reg[CH_TX];
  assign rxCheckPulse = chPulse[CH_RX];
  assign rxCheckCode  = chCode[CH_RX];
  assign txCheckPulse = chPulse[CH_TX];
  assign txCheckCode  = chCode[CH_TX];
endmodule

//--- verif/tlp_link_chk.sv
// Purpose: Watches the stream between the checking end and the user end.
// Assumes: One clock; beats qualified by valid.
// Notes: Bad packets must never show up on the user stream.
`timescale 1ns/10ps
module tlp_link_chk
  import tlp_check_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rstn,
  // Stream signals.
  input wire logic [31:0] rxData,
  input wire logic        rxValid,
  input wire logic        rxSop,
  input wire logic        rxEop,
  input wire logic [31:0] txData,
  input wire logic        txValid,
  input wire logic        txSop,
  input wire logic        txEop
);
  logic [1:0] inPkt_reg;
  logic [1:0] inPkt_next;

  // Open packet flags, transmit high and receive low.
  assign inPkt_next = {txValid ? !txEop : inPkt_reg[1], rxValid ? !rxEop : inPkt_reg[0]};

  // Framing state kept so stray beats are caught.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      inPkt_reg <= 2'h0;
    end else begin
      inPkt_reg <= inPkt_next;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  rx_frame_a: assert property (rxValid && !inPkt_reg[0] |-> rxSop) else $error("rx beat outside packet");
  rx_sop_a: assert property (rxSop |-> rxValid && !inPkt_reg[0]) else $error("rx start misplaced");
  rx_eop_a: assert property (rxEop |-> rxValid) else $error("rx end without valid");
  rx_hdr_a: assert property (rxSop |-> !rxEop) else $error("rx packet too short");
  io_clean_a: assert property (rxSop && rxData[28:24] == TYPE_IO |->
    rxData[22:20] == 3'h0 && rxData[13:0] == 14'h0001) else $error("bad io request passed");
  cfg_clean_a: assert property (rxSop && rxData[28:25] == TYPE_CFG_HI4 |->
    rxData[22:20] == 3'h0 && rxData[13:0] == 14'h0001) else $error("bad cfg request passed");
  tx_frame_a: assert property (txValid && !inPkt_reg[1] |-> txSop) else $error("tx beat outside packet");
  tx_eop_a: assert property (txEop |-> txValid) else $error("tx end without valid");

  // Main traffic shapes seen.
  cover property (rxSop && rxData[30]);
  cover property (txSop && txValid);
  cover property (rxEop ##1 !rxValid);
endmodule

//--- verif/received_tlp_malformed_checker_bench.sv
// Purpose: Sends packets both ways and checks drops and codes.
// Assumes: Store and forward, one packet at a time.
// Notes: Each run watches 150 cycles, enough for a 36 beat replay.
`timescale 1ns/10ps
module received_tlp_malformed_checker_bench;
  import tlp_check_pkg::*;
  logic clk, rstn, rV, rS, rE, rdy, tV, tS, tE, ext, dsp, lV, mp, txP;
  logic [31:0] rD, tD, lD;
  logic [2:0] mps;
  err_code_type mc, txC;
  logic [31:0] pk[$];
  int fail_count = 0, check_count = 0;
  tlp_link_if lnk();

  rx_malformed_checker rx_malformed_checker_i (.clk(clk), .rstn(rstn), .user(lnk), .linkRxData(rD),
    .linkRxValid(rV), .linkRxSop(rS), .linkRxEop(rE), .linkRxReady(rdy), .linkTxData(lD), .linkTxValid(lV),
    .linkTxSop(), .linkTxEop(), .maxPayloadCode(mps), .extTagEnable(ext), .downstreamPort(dsp),
    .malformedPulse(mp), .malformedCode(mc));
  user_tlp_checker user_tlp_checker_i (.clk(clk), .rstn(rstn), .link(lnk), .appRxData(), .appRxValid(),
    .appRxSop(), .appRxEop(), .appTxData(tD), .appTxValid(tV), .appTxSop(tS), .appTxEop(tE),
    .extTagEnable(ext), .rxCheckPulse(), .rxCheckCode(), .txCheckPulse(txP), .txCheckCode(txC));
  tlp_link_chk tlp_link_chk_i (.clk(clk), .rstn(rstn), .rxData(lnk.rxData), .rxValid(lnk.rxValid),
    .rxSop(lnk.rxSop), .rxEop(lnk.rxEop), .txData(lnk.txData), .txValid(lnk.txValid), .txSop(lnk.txSop),
    .txEop(lnk.txEop));

  task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      fail_count++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic chk_code(input string nm, input err_code_type ex, input err_code_type got);
    check_count++;
    if (got !== ex) begin
      fail_count++;
      $display("wrong value %s code exp %h got %h", nm, ex, got);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic mk(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2, input int nd);
    pk = {w0, w1, w2};
    for (int i = 0; i < nd; i++) pk.push_back(32'h5A5A0000 ^ 32'(i));
  endtask

  // Sends the packet on one stream while counting what comes out.
  task automatic run(input string nm, input bit tx, input err_code_type ex);
    int nb = 0, np = 0, nt = 0, last;
    logic r;
    logic [31:0] f = 32'h0;
    last = pk.size() - 1;
    @(posedge clk);
    fork
      begin
        for (int i = 0; i <= last; i++) begin
          if (tx) begin
            {tD, tV, tS, tE} <= {pk[i], 1'b1, i == 0, i == last};
            @(posedge clk);
          end else begin
            {rD, rV, rS, rE} <= {pk[i], 1'b1, i == 0, i == last};
            do begin
              @(negedge clk);
              r = rdy;
              @(posedge clk);
            end while (r !== 1'b1);
          end
        end
        {tV, tS, tE, rV, rS, rE} <= 6'h0;
      end
      repeat (150) begin
        @(negedge clk);
        nb += tx ? (lV === 1'b1) : (lnk.rxValid === 1'b1);
        np += (mp === 1'b1);
        nt += (txP === 1'b1);
        if (!tx && lnk.rxSop === 1'b1) f = lnk.rxData;
        if (tx && lnk.txSop === 1'b1) f = lnk.txData;
      end
    join
    chk_val({nm, " beats"}, (tx || ex == ERR_NONE) ? 32'(pk.size()) : 32'h0, 32'(nb));
    chk_val({nm, " drops"}, 32'(!tx && ex != ERR_NONE), 32'(np));
    if (tx) chk_val({nm, " tx flags"}, 32'(ex != ERR_NONE), 32'(nt));
    if (ex != ERR_NONE) chk_code(nm, ex, tx ? txC : mc);
    if (tx || ex == ERR_NONE) chk_val({nm, " dw0"}, pk[0], f);
    $display("done %s", nm);
  endtask

  // Free running clock at 100 MHz.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short; the runs need about 3000 cycles.
  initial begin
    #100us;
    fail_count++;
    end_sim();
  end

  // Packet list: each case hits one check, with a legal twin where useful.
  initial begin
    {rstn, rV, rS, rE, tV, tS, tE, ext, dsp, rD, tD} = '0;
    mps = 3'h1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    mk(32'h00000001, 32'h0000000F, 0, 0);
    run("mrd", 0, ERR_NONE);
    mk(32'h40000021, 32'h000000FF, 0, 33);
    run("mps fits", 0, ERR_NONE);
    mps <= 3'h0;
    run("mps over", 0, ERR_PAYLOAD);
    mk(32'h40000002, 32'h000000FF, 0, 1);
    run("short", 0, ERR_LENGTH);
    mk(32'h40008001, 32'h0000000F, 0, 1);
    run("no digest", 0, ERR_DIGEST);
    mk(32'h40008001, 32'h0000000F, 0, 2);
    run("digest", 0, ERR_NONE);
    mk(32'h40000002, 32'h000000FF, 32'h00000FFC, 2);
    run("cross", 0, ERR_BOUNDARY);
    mk(32'h00000002, 32'h000000FF, 32'h00000FFC, 0);
    run("rd cross", 0, ERR_NONE);
    run("tx rd cross", 1, ERR_RD_BOUNDARY);
    mk(32'h02100001, 32'h0000000F, 0, 0);
    run("io tc", 0, ERR_IO);
    mk(32'h02000001, 32'h000000FF, 0, 0);
    run("io be", 0, ERR_IO);
    run("tx be", 1, ERR_BE);
    mk(32'h00000003, 32'h000000F5, 0, 0);
    run("tx be gap", 1, ERR_BE_GAP);
    mk(32'h04000002, 32'h0000000F, 0, 0);
    run("cfg len", 0, ERR_CFG);
    mk(32'h04000001, 32'h0000000F, 32'h00010000, 0);
    run("cfg func", 0, ERR_FUNC);
    mk(32'h00000001, 32'h0000E00F, 0, 0);
    run("tag", 0, ERR_TAG);
    run("tx tag", 1, ERR_TAG);
    ext <= 1'b1;
    run("ext tag", 0, ERR_NONE);
    mk(32'h34000000, 32'h00000020, 0, 1);
    run("intx ep", 0, ERR_INTX_PORT);
    dsp <= 1'b1;
    run("intx ds", 0, ERR_NONE);
    mk(32'h34100000, 32'h00000020, 0, 1);
    run("intx tc", 0, ERR_INTX_TC);
    end_sim();
  end
endmodule
